// file: rtl/pin_select_pkg.sv
// Constants shared by the port A/B pin function select logic.
`default_nettype none
package pin_select_pkg;
    localparam int          REG_WIDTH       = 16;
    localparam int          ADDR_WIDTH      = 4;
    localparam logic [3:0]  ADDR_PA_LOW_FN  = 4'h0;
    localparam logic [3:0]  ADDR_PB_DIR     = 4'h1;
    localparam logic [3:0]  ADDR_PB_UPPER   = 4'h2;
    localparam logic [3:0]  ADDR_PB_LOWER   = 4'h3;
    localparam logic [15:0] PA_LOW_FN_RESET = 16'hFF95;
    localparam logic [15:0] PA_LOW_FN_ONES  = 16'hAA00;
    localparam logic [15:0] PB_DIR_RESET    = 16'h0000;
    localparam logic [15:0] PB_FN_RESET     = 16'h0000;
    localparam int          BIT_PIN7        = 14;
    localparam int          BIT_PIN6        = 12;
    localparam int          BIT_PIN5        = 10;
    localparam int          BIT_PIN4        = 8;
    localparam int          FLD_PIN3        = 6;
    localparam int          FLD_PIN2        = 4;
    localparam int          FLD_PIN1        = 2;
    localparam int          FLD_PIN0        = 0;
    localparam logic [1:0]  FN_GPIO         = 2'h0;
    localparam logic [1:0]  FN_ALT1         = 2'h1;
    localparam logic [1:0]  FN_ALT2         = 2'h2;
    localparam logic [1:0]  PB_FN_SERIAL    = 2'h2;
    localparam int          PB_SERIAL_PIN0  = 12;
    localparam int          PB_SERIAL_PIN1  = 13;
endpackage : pin_select_pkg
`default_nettype wire

// file: rtl/pin_output_cell.sv
// One pin's output and enable flip-flops.
`default_nettype none
module pin_output_cell (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic out_d,
    input  wire logic oe_n_d,
    output var  logic out_q,
    output var  logic oe_n_q
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
        end
    end
endmodule : pin_output_cell
`default_nettype wire

// file: rtl/port_ab_pin_function_select.sv
// Port A low pin muxing, port B direction and port B function registers.
//
// Notes on behaviour
// - The unused odd positions 15, 13, 11, 9 of the port A low function register read as 1.
// - Bit 14 selects pin 7 as general I/O when 0 or bus-grant acknowledge when 1, reset 1.
// - Bit 12 selects pin 6 as general I/O when 0 or read strobe when 1, reset 1.
// - Bit 10 selects pin 5 as general I/O or high half / low byte strobe, reset 1.
// - Bit 8 selects pin 4 as general I/O or low half / single store strobe, reset 1.
// - Bits 7:6 select pin 3: I/O, chip select seven, wait input (reset), reserved.
// - The pin 3 pull-up works only in wait mode, as the bus controller asks.
// - Bits 5:4 select pin 2: I/O, chip select six (reset), timer 0 capture B, reserved.
// - Bits 3:2 select pin 1: I/O, chip select five (reset), row address strobe, reserved.
// - Bits 1:0 select pin 0: I/O, chip select four (reset), timer 0 capture A, reserved.
// - A port B direction bit of 1 makes the pin an output, 0 an input.
// - Port B direction applies only for I/O, timer capture or serial clock functions; here only for I/O, and serial clock on pins 12 and 13.
// - Port B direction clears on power-on reset only.
// - Two 16-bit port B function registers cover the upper and lower eight pins.
// - Both port B function registers clear on power-on reset only.
// - The port A low function register loads its pattern on power-on reset only.
`default_nettype none
module port_ab_pin_function_select
    import pin_select_pkg::*;
(
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst_n,
    input  wire logic [pin_select_pkg::ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [pin_select_pkg::REG_WIDTH-1:0]  reg_wdata,
    input  wire logic                                 reg_write,
    input  wire logic                                 reg_read,
    output var  logic [pin_select_pkg::REG_WIDTH-1:0]  reg_rdata,
    // Port A low pins 7..0
    input  wire logic [7:0]                           pa_pin_in,
    output var  logic [7:0]                           pa_pin_out,
    output var  logic [7:0]                           pa_pin_oe_n,
    input  wire logic [7:0]                           pa_gpio_out,
    input  wire logic [7:0]                           pa_gpio_dir,
    output var  logic [7:0]                           pa_gpio_in,
    // Peripheral sides
    input  wire logic                                 bus_grant_ack,
    input  wire logic                                 read_strobe,
    input  wire logic                                 high_half_store_strobe,
    input  wire logic                                 low_half_store_strobe,
    input  wire logic                                 chip_select_seven,
    input  wire logic                                 chip_select_six,
    input  wire logic                                 chip_select_five,
    input  wire logic                                 chip_select_four,
    input  wire logic                                 row_address_strobe,
    input  wire logic                                 wait_pullup_request,
    output var  logic                                 wait_in,
    output var  logic                                 pin3_pullup_en,
    input  wire logic                                 timer0_capture_a_out,
    input  wire logic                                 timer0_capture_a_oe,
    output var  logic                                 timer0_capture_a_in,
    input  wire logic                                 timer0_capture_b_out,
    input  wire logic                                 timer0_capture_b_oe,
    output var  logic                                 timer0_capture_b_in,
    // Port B
    output var  logic [pin_select_pkg::REG_WIDTH-1:0]  pb_dir_out,
    input  wire logic [pin_select_pkg::REG_WIDTH-1:0]  pb_alt_oe_n,
    output var  logic [pin_select_pkg::REG_WIDTH-1:0]  pb_pin_oe_n,
    output var  logic [pin_select_pkg::REG_WIDTH-1:0]  port_b_upper_function,
    output var  logic [pin_select_pkg::REG_WIDTH-1:0]  port_b_lower_function
);
    import pin_select_pkg::*;

    logic [REG_WIDTH-1:0] pa_fn_q;
    logic [REG_WIDTH-1:0] pb_dir_q;
    logic [REG_WIDTH-1:0] pb_up_q;
    logic [REG_WIDTH-1:0] pb_lo_q;
    logic [7:0]           pa_meta_q;
    logic [7:0]           pa_sync_q;
    logic [7:0]           out_d;
    logic [7:0]           oe_n_d;
    logic [1:0]           sel3;
    logic [1:0]           sel2;
    logic [1:0]           sel1;
    logic [1:0]           sel0;
    logic [31:0]          pb_fn_all;
    logic [REG_WIDTH-1:0] pb_dir_used;
    logic [REG_WIDTH-1:0] pb_oe_n_d;

    // Only rst_n (power-on) clears; there is no manual-reset input by design
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pa_fn_q <= PA_LOW_FN_RESET;
        end else if (reg_write && reg_addr == ADDR_PA_LOW_FN) begin
            pa_fn_q <= reg_wdata | PA_LOW_FN_ONES;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pb_dir_q <= PB_DIR_RESET;
        end else if (reg_write && reg_addr == ADDR_PB_DIR) begin
            pb_dir_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pb_up_q <= PB_FN_RESET;
        end else if (reg_write && reg_addr == ADDR_PB_UPPER) begin
            pb_up_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pb_lo_q <= PB_FN_RESET;
        end else if (reg_write && reg_addr == ADDR_PB_LOWER) begin
            pb_lo_q <= reg_wdata;
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_PA_LOW_FN: reg_rdata <= pa_fn_q | PA_LOW_FN_ONES;
                ADDR_PB_DIR:    reg_rdata <= pb_dir_q;
                ADDR_PB_UPPER:  reg_rdata <= pb_up_q;
                ADDR_PB_LOWER:  reg_rdata <= pb_lo_q;
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Pin inputs come from outside, two stages first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pa_meta_q <= '0;
            pa_sync_q <= '0;
        end else begin
            pa_meta_q <= pa_pin_in;
            pa_sync_q <= pa_meta_q;
        end
    end

    // Two-bit function fields of pins 3..0
    assign sel3 = pa_fn_q[FLD_PIN3 +: 2];
    assign sel2 = pa_fn_q[FLD_PIN2 +: 2];
    assign sel1 = pa_fn_q[FLD_PIN1 +: 2];
    assign sel0 = pa_fn_q[FLD_PIN0 +: 2];

    // Reserved codes float the pin: safer than guessing a function
    always_comb begin
        // GPIO first; a selected function overrides it
        out_d  = pa_gpio_out;
        oe_n_d = ~pa_gpio_dir;
        if (pa_fn_q[BIT_PIN7]) begin
            out_d[7]  = bus_grant_ack;
            oe_n_d[7] = 1'b0;
        end
        if (pa_fn_q[BIT_PIN6]) begin
            out_d[6]  = read_strobe;
            oe_n_d[6] = 1'b0;
        end
        if (pa_fn_q[BIT_PIN5]) begin
            out_d[5]  = high_half_store_strobe;
            oe_n_d[5] = 1'b0;
        end
        if (pa_fn_q[BIT_PIN4]) begin
            out_d[4]  = low_half_store_strobe;
            oe_n_d[4] = 1'b0;
        end
        case (sel3)
            FN_GPIO: ;
            FN_ALT1: begin
                out_d[3]  = chip_select_seven;
                oe_n_d[3] = 1'b0;
            end
            default: oe_n_d[3] = 1'b1;
        endcase
        case (sel2)
            FN_GPIO: ;
            FN_ALT1: begin
                out_d[2]  = chip_select_six;
                oe_n_d[2] = 1'b0;
            end
            FN_ALT2: begin
                out_d[2]  = timer0_capture_b_out;
                oe_n_d[2] = ~timer0_capture_b_oe;
            end
            default: oe_n_d[2] = 1'b1;
        endcase
        case (sel1)
            FN_GPIO: ;
            FN_ALT1: begin
                out_d[1]  = chip_select_five;
                oe_n_d[1] = 1'b0;
            end
            FN_ALT2: begin
                out_d[1]  = row_address_strobe;
                oe_n_d[1] = 1'b0;
            end
            default: oe_n_d[1] = 1'b1;
        endcase
        case (sel0)
            FN_GPIO: ;
            FN_ALT1: begin
                out_d[0]  = chip_select_four;
                oe_n_d[0] = 1'b0;
            end
            FN_ALT2: begin
                out_d[0]  = timer0_capture_a_out;
                oe_n_d[0] = ~timer0_capture_a_oe;
            end
            default: oe_n_d[0] = 1'b1;
        endcase
    end

    // One cell per pin so every pad output leaves a flip-flop
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pa_pin
            pin_output_cell u_cell (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .out_d   (out_d[gi]),
                .oe_n_d  (oe_n_d[gi]),
                .out_q   (pa_pin_out[gi]),
                .oe_n_q  (pa_pin_oe_n[gi])
            );
        end
    endgenerate

    // Inputs returned to GPIO ungated; the peripheral inputs below are gated by function
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pa_gpio_in <= '0;
        end else begin
            pa_gpio_in <= pa_sync_q;
        end
    end

    // Idle level high so the bus controller never sees a false wait
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_in        <= 1'b1;
            pin3_pullup_en <= 1'b0;
        end else begin
            wait_in        <= (sel3 == FN_ALT2) ? pa_sync_q[3] : 1'b1;
            pin3_pullup_en <= (sel3 == FN_ALT2) && wait_pullup_request;
        end
    end

    // Unselected capture inputs rest low so the timer sees no edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer0_capture_a_in <= 1'b0;
            timer0_capture_b_in <= 1'b0;
        end else begin
            timer0_capture_a_in <= (sel0 == FN_ALT2) ? pa_sync_q[0] : 1'b0;
            timer0_capture_b_in <= (sel2 == FN_ALT2) ? pa_sync_q[2] : 1'b0;
        end
    end

    // Port B: field per pin, lower register holds pins 7..0
    assign pb_fn_all = {pb_up_q, pb_lo_q};

    generate
        for (gi = 0; gi < REG_WIDTH; gi++) begin : g_pb_pin
            // Timer functions of port B live in encodings outside this block;
            // pins left at I/O or switched to serial clock honour direction
            if (gi == PB_SERIAL_PIN0 || gi == PB_SERIAL_PIN1) begin : g_ser
                assign pb_dir_used[gi] = (pb_fn_all[2*gi +: 2] == FN_GPIO)
                                      || (pb_fn_all[2*gi +: 2] == PB_FN_SERIAL);
            end else begin : g_plain
                assign pb_dir_used[gi] = (pb_fn_all[2*gi +: 2] == FN_GPIO);
            end
            assign pb_oe_n_d[gi] = pb_dir_used[gi] ? ~pb_dir_q[gi] : pb_alt_oe_n[gi];
        end
    endgenerate

    // All port B pins released until software picks a direction or a non-I/O function
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pb_dir_out  <= PB_DIR_RESET;
            pb_pin_oe_n <= '1;
        end else begin
            pb_dir_out  <= pb_dir_q;
            pb_pin_oe_n <= pb_oe_n_d;
        end
    end

    // Copies for the port B function mux, which lives outside this block
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_b_upper_function <= PB_FN_RESET;
            port_b_lower_function <= PB_FN_RESET;
        end else begin
            port_b_upper_function <= pb_up_q;
            port_b_lower_function <= pb_lo_q;
        end
    end
endmodule : port_ab_pin_function_select
`default_nettype wire

// file: tb/pin_select_assertions.sv
// Concurrent checks on the ports of the pin function select block.
`default_nettype none
module pin_select_checker
    import pin_select_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [REG_WIDTH-1:0]  reg_wdata,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire logic [REG_WIDTH-1:0]  reg_rdata,
    input wire logic [7:0]            pa_pin_oe_n,
    input wire logic                  pin3_pullup_en,
    input wire logic                  wait_in,
    input wire logic [REG_WIDTH-1:0]  pb_dir_out,
    input wire logic [REG_WIDTH-1:0]  port_b_upper_function,
    input wire logic [REG_WIDTH-1:0]  port_b_lower_function
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // A write must show two edges later unless the same place is written again
    property p_lands(logic [3:0] a, logic [15:0] q);
        reg_write && reg_addr == a ##1 !(reg_write && reg_addr == a)
            |-> ##1 q == $past(reg_wdata, 2);
    endproperty
    a_read_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside its slot");
    a_pa_reads_ones: assert property ($past(reg_read) && $past(reg_addr) == ADDR_PA_LOW_FN
        |-> (reg_rdata & PA_LOW_FN_ONES) == PA_LOW_FN_ONES)
        else $error("port A function reserved bits not read as one");
    a_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) > ADDR_PB_LOWER
        |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_pa_write_back: assert property (reg_write && reg_addr == ADDR_PA_LOW_FN
        ##1 reg_read && reg_addr == ADDR_PA_LOW_FN
        |-> ##1 reg_rdata == ($past(reg_wdata, 2) | PA_LOW_FN_ONES))
        else $error("port A function read back wrong");
    a_dir_lands: assert property (p_lands(ADDR_PB_DIR, pb_dir_out))
        else $error("direction write not applied");
    a_upper_lands: assert property (p_lands(ADDR_PB_UPPER, port_b_upper_function))
        else $error("upper function write not applied");
    a_lower_lands: assert property (p_lands(ADDR_PB_LOWER, port_b_lower_function))
        else $error("lower function write not applied");
    a_pullup_released: assert property (pin3_pullup_en |-> pa_pin_oe_n[3])
        else $error("pull-up on while pin 3 is driven");
    a_wait_idle_high: assert property (!pa_pin_oe_n[3] && $past(!pa_pin_oe_n[3]) |-> wait_in)
        else $error("wait input not high while pin 3 drives");
    c_pa_read: cover property (reg_read && reg_addr == ADDR_PA_LOW_FN);
    c_pullup: cover property (pin3_pullup_en);
    c_pin3_drive: cover property (!pa_pin_oe_n[3]);
endmodule : pin_select_checker
bind port_ab_pin_function_select pin_select_checker pin_select_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pa_pin_oe_n(pa_pin_oe_n), .pin3_pullup_en(pin3_pullup_en), .wait_in(wait_in),
    .pb_dir_out(pb_dir_out), .port_b_upper_function(port_b_upper_function),
    .port_b_lower_function(port_b_lower_function));
`default_nettype wire

// file: tb/pin_select_partner.sv
// Model of the on-chip peripherals and the board around the port A pins.
`default_nettype none
module pin_select_partner (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  pa_pin_out,
    input  wire logic [7:0]  pa_pin_oe_n,
    input  wire logic        pin3_pullup_en,
    output var  logic [45:0] stim,
    output var  logic [7:0]  pa_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_q;
    // Levels move every cycle so a stale mux path cannot pass by luck
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stim <= '0;
            float_q <= 8'h00;
        end else begin
            stim <= 46'({$urandom, $urandom});
            float_q <= ~float_q ^ 8'($urandom);
        end
    end
    // Released pins wander; pin 3 rests high only while its pull-up is on
    always_comb begin
        pa_pin_in = (pa_pin_out & ~pa_pin_oe_n) | (float_q & pa_pin_oe_n);
        if (pa_pin_oe_n[3] && pin3_pullup_en) pa_pin_in[3] = 1'b1;
    end
endmodule : pin_select_partner
`default_nettype wire

// file: tb/port_ab_pin_function_select_bench.sv
// Self-checking bench for the port A/B pin function select block.
`default_nettype none
module port_ab_pin_function_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_select_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] sh [4];
    logic [45:0] s_prev;
    int err_count = 0, n_compared = 0;
    logic [23:0] pin_hist;
    wire logic [15:0] reg_rdata, pb_pin_oe_n, pb_dir_out;
    wire logic [15:0] port_b_upper_function, port_b_lower_function;
    wire logic [7:0] pa_pin_out, pa_pin_oe_n, pa_pin_in, pa_gpio_in;
    wire logic [45:0] stim;
    wire logic wait_in, pin3_pullup_en, timer0_capture_a_in, timer0_capture_b_in;
    port_ab_pin_function_select port_ab_pin_function_select_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out), .pa_pin_oe_n(pa_pin_oe_n),
        .pa_gpio_out(stim[21:14]), .pa_gpio_dir(stim[29:22]), .pa_gpio_in(pa_gpio_in),
        .bus_grant_ack(stim[0]), .read_strobe(stim[1]), .high_half_store_strobe(stim[2]),
        .low_half_store_strobe(stim[3]), .chip_select_seven(stim[4]),
        .chip_select_six(stim[5]), .chip_select_five(stim[6]), .chip_select_four(stim[7]),
        .row_address_strobe(stim[8]), .wait_pullup_request(stim[9]), .wait_in(wait_in),
        .pin3_pullup_en(pin3_pullup_en), .timer0_capture_a_out(stim[10]),
        .timer0_capture_a_oe(stim[11]), .timer0_capture_a_in(timer0_capture_a_in),
        .timer0_capture_b_out(stim[12]), .timer0_capture_b_oe(stim[13]),
        .timer0_capture_b_in(timer0_capture_b_in), .pb_dir_out(pb_dir_out),
        .pb_alt_oe_n(stim[45:30]), .pb_pin_oe_n(pb_pin_oe_n),
        .port_b_upper_function(port_b_upper_function),
        .port_b_lower_function(port_b_lower_function));
    pin_select_partner pin_select_partner_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .pa_pin_out(pa_pin_out), .pa_pin_oe_n(pa_pin_oe_n), .pin3_pullup_en(pin3_pullup_en),
        .stim(stim), .pa_pin_in(pa_pin_in));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Pin levels three cycles back, the depth of the input path
    always_ff @(negedge clk_sys) pin_hist <= {pin_hist[15:0], pa_pin_in};
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_read <= 1'b0;
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        chk("reg_rdata", reg_rdata, exp);
        @(posedge clk_sys);
    endtask : rd
    task automatic check_regs();
        rd(ADDR_PA_LOW_FN, sh[0]);
        rd(ADDR_PB_DIR, sh[1]);
        rd(ADDR_PB_UPPER, sh[2]);
        rd(ADDR_PB_LOWER, sh[3]);
        rd(4'hC, 16'h0000);
    endtask : check_regs
    function automatic logic [15:0] exp_pa(input logic [15:0] f, input logic [45:0] s);
        logic [7:0] o;
        logic [7:0] e;
        e = ~s[29:22];
        o = s[21:14];
        for (int i = 0; i < 4; i++) begin
            if (f[8 + 2 * i]) begin
                e[4 + i] = 1'b0;
                o[4 + i] = s[3 - i];
            end
            if (f[2 * i +: 2] == 2'h1) begin
                e[i] = 1'b0;
                o[i] = s[7 - i];
            end
            if (f[2 * i +: 2] == 2'h2) begin
                e[i] = (i == 3) | (i == 2 & ~s[13]) | (i == 0 & ~s[11]);
                o[i] = (i == 2) ? s[12] : (i == 1) ? s[8] : s[10];
            end
            if (f[2 * i +: 2] == 2'h3) e[i] = 1'b1;
        end
        return {o & ~e, e};
    endfunction : exp_pa
    function automatic logic [15:0] exp_pb(input logic [15:0] alt);
        logic [31:0] fn;
        logic [1:0] m;
        fn = {sh[2], sh[3]};
        for (int i = 0; i < 16; i++) begin
            m = fn[2 * i +: 2];
            exp_pb[i] = (m == FN_GPIO || (m == PB_FN_SERIAL && (i == PB_SERIAL_PIN0
                || i == PB_SERIAL_PIN1))) ? ~sh[1][i] : alt[i];
        end
    endfunction : exp_pb
    function automatic logic [15:0] exp_in(input logic [15:0] f, input logic [7:0] p);
        return {5'h00, p, (f[7:6] != 2'h2) | p[3], (f[1:0] == 2'h2) & p[0],
            (f[5:4] == 2'h2) & p[2]};
    endfunction : exp_in
    task automatic watch(input int n);
        logic [15:0] pins;
        logic [15:0] ins;
        @(negedge clk_sys);
        s_prev = stim;
        chk("pb_dir_out", pb_dir_out, sh[1]);
        chk("pb_upper_fn", port_b_upper_function, sh[2]);
        chk("pb_lower_fn", port_b_lower_function, sh[3]);
        repeat (n) begin
            @(negedge clk_sys);
            pins = {pa_pin_out & ~pa_pin_oe_n, pa_pin_oe_n};
            chk("pa_pins", pins, exp_pa(sh[0], s_prev));
            chk("pb_oe_n", pb_pin_oe_n, exp_pb(s_prev[45:30]));
            ins = {5'h00, pa_gpio_in, wait_in, timer0_capture_a_in, timer0_capture_b_in};
            chk("pin_inputs", ins, exp_in(sh[0], pin_hist[23:16]));
            chk("pin3_aux", {pin3_pullup_en, wait_in | (sh[0][7:6] == 2'h2)},
                {sh[0][7:6] == 2'h2 && s_prev[9], 1'b1});
            s_prev = stim;
        end
        @(posedge clk_sys);
    endtask : watch
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [15:0] corner [6] = '{16'hAA00, 16'hFF55, 16'hFFAA, 16'hAAFF, 16'hFF95, 16'hFF00};
        void'($urandom(32'h89E7));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        sh = '{PA_LOW_FN_RESET, PB_DIR_RESET, PB_FN_RESET, PB_FN_RESET};
        check_regs();
        watch(4);
        for (int k = 0; k < 24; k++) begin
            sh[0] = (k < 6) ? corner[k] : (16'($urandom) | PA_LOW_FN_ONES);
            sh[1] = 16'($urandom);
            sh[2] = (k < 6) ? 16'h0A00 : 16'($urandom);
            sh[3] = 16'($urandom);
            wr(ADDR_PB_DIR, sh[1]);
            wr(ADDR_PB_UPPER, sh[2]);
            wr(ADDR_PB_LOWER, sh[3]);
            wr(4'hC, 16'hFFFF);
            wr(ADDR_PA_LOW_FN, (k == 0) ? 16'h0000 : sh[0]);
            check_regs();
            watch(6);
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        sh = '{PA_LOW_FN_RESET, PB_DIR_RESET, PB_FN_RESET, PB_FN_RESET};
        check_regs();
        watch(4);
        wrap_up();
    end
endmodule : port_ab_pin_function_select_bench
`default_nettype wire
